// ===== hdl/reading_ram.sv
// Reading memory: one write port and two registered read ports.
`timescale 1ns/10ps
module reading_ram
  import rstore_pkg::*;
(
  // Clock
  input  wire logic          aclk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read ports
  input  wire logic [AW-1:0] raddr_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [DW-1:0] rdata_a,
  output logic      [DW-1:0] rdata_b
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule // reading_ram

// ===== hdl/reading_store.sv
// Reading store controller: triggers, storage, recall and talk-only output.
// Operation
// - One-shot mode: each accepted stimulus stores exactly one reading.
// - The front-panel key triggers whatever source is configured.
// - External source: each input pulse is one stimulus, one reading.
// - Operate source: each standby-to-operate change stores one reading.
// - Interval writes are refused while one-shot mode is active.
// - One-shot: reading waits for the trigger delay after each stimulus.
// - Stimulus during a running delay is dropped and flags an overrun.
// - Entering recall shows location 001 first.
// - Stepping back below location 001 shows maximum, then minimum.
// - Stepping forward advances one location, stopping at the last valid.
// - In recall a location may be entered one digit at a time.
// - Recall of an empty store reports no data instead of a reading.
// - Storage continues during recall; stops when full unless wrapping.
// - Talk-only sends each completed conversion that finds the output stage free, without being addressed.
// - A slow listener never slows the measurement rate.
// - Stored source during storage: each reading that finds the output stage free is sent as stored.
// - Talk-only after storage with stored source dumps all readings, each one waiting for the output stage to empty.
// - Armed indication clears when the last reading of a finite run lands.
// - The store holds at most 512 readings; runs stop at buffer size.
// - Buffer size 000 means continuous wrap-around storage.
// - Arming the store invalidates all stored readings.
// - Changing mode, interval, delay or source disarms the store.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module reading_store
  import rstore_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite register slave
  input  wire logic [RA_W-1:0]   awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [RA_W-1:0]   araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Trigger inputs and measurement path
  input  wire logic              ext_trig_n,
  input  wire logic              source_operate,
  input  wire logic [DW-1:0]     reading_in,
  input  wire logic              conv_valid,
  output logic                   meas_trigger,
  output logic                   store_armed,
  output logic                   trigger_overrun_error,
  // Talk-only listener stream
  output logic [DW-1:0]          tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready
);
  // ****************************************
  // Register bus front end
  // ****************************************
  logic            aw_q, w_q, bvalid_q, rvalid_q, do_wr;
  logic [RA_W-1:0] awaddr_q;
  logic [31:0]     wdata_q, rdata_q, wmask, wv, rd_word;
  logic [3:0]      wstrb_q;
  logic [1:0]      bresp_q, rresp_q, bresp_d, rd_resp;

  assign awready = !aw_q && !bvalid_q;
  assign wready  = !w_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign do_wr   = aw_q && w_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
  end
  assign wv = wdata_q & wmask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_q     <= 1'b1;
      awaddr_q <= awaddr;
    end else if (do_wr) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q     <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_q     <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (do_wr) begin
      w_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= bresp_d;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_resp;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Write decode and configuration
  // ****************************************
  cfg_s             cfg_q;
  logic [DLY_W-1:0] delay_q, intvl_q;
  logic [9:0]       bufsize_q;
  logic [6:0]       cmd;
  logic [31:0]      ctrl_w, dly_w, int_w, buf_w;
  logic             wr_ctrl, wr_dly, wr_int, wr_buf, wr_dig, cfg_change;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_dly  = 1'b0;
    wr_int  = 1'b0;
    wr_buf  = 1'b0;
    wr_dig  = 1'b0;
    cmd     = '0;
    bresp_d = RESP_OKAY;
    if (do_wr) begin
      case (awaddr_q)
        OFS_CTRL:    wr_ctrl = 1'b1;
        OFS_DELAY:   wr_dly = 1'b1;
        OFS_INTVL:   begin
          if (cfg_q.single_shot) bresp_d = RESP_SLVERR;
          else wr_int = 1'b1;
        end
        OFS_BUFSIZE: wr_buf = 1'b1;
        OFS_CMD:     cmd = wv[6:0];
        OFS_DIGIT:   wr_dig = 1'b1;
        default:     bresp_d = RESP_SLVERR;
      endcase
    end
  end

  assign ctrl_w = (32'(cfg_q) & ~wmask) | wv;
  assign dly_w  = (32'(delay_q) & ~wmask) | wv;
  assign int_w  = (32'(intvl_q) & ~wmask) | wv;
  assign buf_w  = (32'(bufsize_q) & ~wmask) | wv;
  assign cfg_change = (wr_ctrl && ctrl_w[2:0] != 3'(cfg_q))
                   || (wr_dly && dly_w[DLY_W-1:0] != delay_q)
                   || (wr_int && int_w[DLY_W-1:0] != intvl_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= CFG_RST;
      delay_q   <= DELAY_RST;
      intvl_q   <= INTVL_RST;
      bufsize_q <= BUFSIZE_RST;
    end else begin
      if (wr_ctrl) cfg_q <= cfg_s'(ctrl_w[4:0]);
      if (wr_dly) delay_q <= dly_w[DLY_W-1:0];
      if (wr_int) intvl_q <= int_w[DLY_W-1:0];
      if (wr_buf) bufsize_q <= (buf_w > 32'(BUF_MAX)) ? BUF_MAX : buf_w[9:0];
    end
  end

  // ****************************************
  // Trigger sources and delay
  // ****************************************
  logic ext_q, oper_q, stim, accepted, ovr, dly_busy, fire, ovr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q  <= 1'b1;
      oper_q <= 1'b1;
    end else begin
      ext_q  <= ext_trig_n;
      oper_q <= source_operate;
    end
  end

  assign stim = cmd[CMD_KEY]
             || (cfg_q.src == SRC_EXT && ext_q && !ext_trig_n)
             || (cfg_q.src == SRC_OPER && !oper_q && source_operate);
  assign accepted = stim && !dly_busy;

  trigger_delay u_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .stim    (stim),
    .delay   (delay_q),
    .fire    (fire),
    .overrun (ovr),
    .busy    (dly_busy)
  );

  // The flag must outlive the one-cycle overrun pulse so status polling sees it.
  always_ff @(posedge aclk) begin
    if (!aresetn) ovr_q <= 1'b0;
    else if (ovr) ovr_q <= 1'b1;
    else if (cmd[CMD_ACK] || accepted) ovr_q <= 1'b0;
  end

  // ****************************************
  // Storage run
  // ****************************************
  logic                 armed_q, run_q, store_we, last_wr, no_data;
  logic [AW-1:0]        wr_ptr_q;
  logic [9:0]           count_q, run_cnt_q;
  logic signed [DW-1:0] max_q, min_q;
  logic [DW-1:0]        rdata_a, rdata_b;

  // Storage does not look at recall state, so it runs on during recall.
  assign store_we = armed_q && (cfg_q.single_shot ? fire : run_q && conv_valid);
  assign last_wr  = store_we && bufsize_q != 10'h000 && run_cnt_q + 10'h001 == bufsize_q;
  assign no_data  = count_q == 10'h000;

  always_ff @(posedge aclk) begin
    if (!aresetn) armed_q <= 1'b0;
    else if (cmd[CMD_ARM]) armed_q <= 1'b1;
    else if (cfg_change || last_wr) armed_q <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) run_q <= 1'b0;
    else if (cmd[CMD_ARM] || !armed_q) run_q <= 1'b0;
    else if (fire && !cfg_q.single_shot) run_q <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q  <= '0;
      count_q   <= '0;
      run_cnt_q <= '0;
    end else if (cmd[CMD_ARM]) begin
      wr_ptr_q  <= '0;
      count_q   <= '0;
      run_cnt_q <= '0;
    end else if (store_we) begin
      wr_ptr_q  <= wr_ptr_q + 9'h001;
      count_q   <= (count_q == BUF_MAX) ? BUF_MAX : count_q + 10'h001;
      run_cnt_q <= run_cnt_q + 10'h001;
    end
  end

  // Extremes cover every reading of the run, including any overwritten by wrapping.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_q <= '0;
      min_q <= '0;
    end else if (store_we) begin
      if (no_data || $signed(reading_in) > max_q) max_q <= reading_in;
      if (no_data || $signed(reading_in) < min_q) min_q <= reading_in;
    end
  end

  // ****************************************
  // Recall
  // ****************************************
  logic       recall_q;
  view_e      view_q;
  logic [9:0] loc_q, loc_dig;

  function automatic logic [9:0] set_digit(input logic [9:0] loc, input logic [1:0] idx,
                                           input logic [3:0] val, input logic [9:0] last);
    logic [13:0] h, t, o, s;
    h = 14'(loc / 10'h064);
    t = 14'((loc / 10'h00A) % 10'h00A);
    o = 14'(loc % 10'h00A);
    case (idx)
      2'h0:    o = 14'(val);
      2'h1:    t = 14'(val);
      default: h = 14'(val);
    endcase
    s = h * 14'h0064 + t * 14'h000A + o;
    if (s > 14'(last)) s = 14'(last);
    if (s == 14'h0000) s = 14'h0001;
    return s[9:0];
  endfunction

  assign loc_dig = set_digit(loc_q, wv[5:4], wv[3:0], count_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recall_q <= 1'b0;
      view_q   <= VIEW_LOC;
      loc_q    <= LOC_FIRST;
    end else if (cmd[CMD_ENTER]) begin
      recall_q <= 1'b1;
      view_q   <= VIEW_LOC;
      loc_q    <= LOC_FIRST;
    end else if (cmd[CMD_EXIT]) begin
      recall_q <= 1'b0;
    end else if (recall_q && cmd[CMD_BACK]) begin
      case (view_q)
        VIEW_LOC: begin
          if (loc_q == LOC_FIRST) view_q <= VIEW_MAX;
          else loc_q <= loc_q - 10'h001;
        end
        default:  view_q <= VIEW_MIN;
      endcase
    end else if (recall_q && cmd[CMD_FWD]) begin
      case (view_q)
        VIEW_MIN: view_q <= VIEW_MAX;
        VIEW_MAX: begin
          view_q <= VIEW_LOC;
          loc_q  <= LOC_FIRST;
        end
        default:  if (loc_q < count_q) loc_q <= loc_q + 10'h001;
      endcase
    end else if (recall_q && wr_dig) begin
      view_q <= VIEW_LOC;
      loc_q  <= loc_dig;
    end
  end

  // ****************************************
  // Talk-only output
  // ****************************************
  logic          talk_prev_q, dump_q, dump_pend_q, dump_rd, tx_load, tx_valid_q;
  logic [9:0]    dump_idx_q, oldest;
  logic [DW-1:0] tx_next, tx_data_q;

  assign oldest  = (count_q == BUF_MAX) ? {1'b0, wr_ptr_q} : 10'h000;
  assign dump_rd = dump_q && !dump_pend_q && !tx_valid_q;

  always_comb begin
    tx_load = 1'b0;
    tx_next = reading_in;
    if (dump_pend_q) begin
      tx_load = 1'b1;
      tx_next = rdata_b;
    end else if (cfg_q.talk_only && !cfg_q.stored_src) begin
      tx_load = conv_valid;
    end else if (cfg_q.talk_only) begin
      tx_load = store_we;
    end
  end

  // One holding stage only: a reading arriving while it is full and not being taken by the listener is dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
    end else if (tx_load && (!tx_valid_q || tx_ready)) begin
      tx_valid_q <= 1'b1;
      tx_data_q  <= tx_next;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      talk_prev_q <= 1'b0;
      dump_q      <= 1'b0;
      dump_pend_q <= 1'b0;
      dump_idx_q  <= '0;
    end else begin
      talk_prev_q <= cfg_q.talk_only;
      dump_pend_q <= dump_rd;
      if (cfg_q.talk_only && !talk_prev_q && cfg_q.stored_src && !armed_q && !no_data) begin
        dump_q     <= 1'b1;
        dump_idx_q <= '0;
      end else if (!cfg_q.talk_only || cmd[CMD_ARM]) begin
        dump_q <= 1'b0;
      end else if (dump_rd) begin
        dump_idx_q <= dump_idx_q + 10'h001;
        if (dump_idx_q + 10'h001 == count_q) dump_q <= 1'b0;
      end
    end
  end

  reading_ram u_ram (
    .aclk    (aclk),
    .we      (store_we),
    .waddr   (wr_ptr_q),
    .wdata   (reading_in),
    .raddr_a (AW'(loc_q - 10'h001)),
    .raddr_b (AW'(oldest + dump_idx_q)),
    .rdata_a (rdata_a),
    .rdata_b (rdata_b)
  );

  // ****************************************
  // Read mux and outputs
  // ****************************************
  status_s       st;
  logic [DW-1:0] rec_word;

  assign st = '{count: count_q, view: view_q, tx_busy: tx_valid_q, dump: dump_q,
                no_data: recall_q && no_data, recall: recall_q, overrun: ovr_q,
                run: run_q, armed: armed_q};
  assign rec_word = no_data ? '0
                  : (view_q == VIEW_LOC) ? rdata_a
                  : (view_q == VIEW_MAX) ? max_q : min_q;

  always_comb begin
    rd_word = 32'h00000000;
    rd_resp = RESP_OKAY;
    case (araddr)
      OFS_CTRL:    rd_word = 32'(cfg_q);
      OFS_DELAY:   rd_word = 32'(delay_q);
      OFS_INTVL:   rd_word = 32'(intvl_q);
      OFS_BUFSIZE: rd_word = 32'(bufsize_q);
      OFS_CMD:     rd_word = 32'h00000000;
      OFS_DIGIT:   rd_word = 32'(loc_q);
      OFS_STATUS:  rd_word = 32'(st);
      OFS_RDATA:   rd_word = rec_word;
      OFS_RLOC:    rd_word = 32'(loc_q);
      default:     rd_resp = RESP_SLVERR;
    endcase
  end

  assign meas_trigger          = fire;
  assign store_armed           = armed_q;
  assign trigger_overrun_error = ovr_q;
  assign tx_valid              = tx_valid_q;
  assign tx_data               = tx_data_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Enter and exit take priority over stepping, so both are excluded here.
  sequence s_back_at_first;
    recall_q && !cmd[CMD_ENTER] && !cmd[CMD_EXIT] && view_q == VIEW_LOC
      && loc_q == LOC_FIRST && cmd[CMD_BACK];
  endsequence
  sequence s_back_at_max;
    recall_q && !cmd[CMD_ENTER] && !cmd[CMD_EXIT] && view_q == VIEW_MAX && cmd[CMD_BACK];
  endsequence

  a_key_any_source: assert property (
    cmd[CMD_KEY] && !dly_busy && delay_q == 24'h000000 |=> meas_trigger)
    else $error("Trigger key did not start a reading.");
  a_one_shot_store: assert property (
    cfg_q.single_shot && armed_q && fire |=> wr_ptr_q == 9'($past(wr_ptr_q) + 9'h001))
    else $error("One-shot trigger did not store a reading.");
  a_interval_locked: assert property (
    do_wr && awaddr_q == OFS_INTVL && cfg_q.single_shot |=> $stable(intvl_q) && bresp == RESP_SLVERR)
    else $error("Interval changed in one-shot mode.");
  a_recall_first_loc: assert property (
    cmd[CMD_ENTER] |=> recall_q && loc_q == LOC_FIRST && view_q == VIEW_LOC)
    else $error("Recall did not open at the first location.");
  a_back_to_max: assert property (
    s_back_at_first |=> view_q == VIEW_MAX)
    else $error("Stepping back from the first location missed the maximum.");
  a_max_to_min: assert property (
    s_back_at_max |=> view_q == VIEW_MIN)
    else $error("Stepping back from the maximum missed the minimum.");
  a_last_disarms: assert property (
    last_wr && !cmd[CMD_ARM] |=> !armed_q
      && (count_q == 10'($past(count_q) + 10'h001) || $past(count_q) == BUF_MAX))
    else $error("Armed flag stayed after the final reading.");
  a_change_disarms: assert property (
    cfg_change |=> !armed_q ##1 !armed_q || $past(cmd[CMD_ARM]))
    else $error("Configuration change left the store armed.");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Listener data changed before it was accepted.");
endmodule // reading_store

// ===== hdl/rstore_pkg.sv
// Shared constants and types for the reading store controller.
package rstore_pkg;
  localparam int unsigned DEPTH = 512;
  localparam int unsigned AW    = 9;
  localparam int unsigned DW    = 32;
  localparam int unsigned DLY_W = 24;
  localparam int unsigned RA_W  = 8;
  // Register byte offsets.
  localparam logic [RA_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [RA_W-1:0] OFS_DELAY   = 8'h04;
  localparam logic [RA_W-1:0] OFS_INTVL   = 8'h08;
  localparam logic [RA_W-1:0] OFS_BUFSIZE = 8'h0C;
  localparam logic [RA_W-1:0] OFS_CMD     = 8'h10;
  localparam logic [RA_W-1:0] OFS_DIGIT   = 8'h14;
  localparam logic [RA_W-1:0] OFS_STATUS  = 8'h18;
  localparam logic [RA_W-1:0] OFS_RDATA   = 8'h1C;
  localparam logic [RA_W-1:0] OFS_RLOC    = 8'h20;
  // Command register bit positions.
  localparam int unsigned CMD_ARM   = 0;
  localparam int unsigned CMD_KEY   = 1;
  localparam int unsigned CMD_ENTER = 2;
  localparam int unsigned CMD_EXIT  = 3;
  localparam int unsigned CMD_FWD   = 4;
  localparam int unsigned CMD_BACK  = 5;
  localparam int unsigned CMD_ACK   = 6;
  // Trigger source codes; any other code leaves only the front-panel key.
  localparam logic [1:0] SRC_EXT  = 2'h0;
  localparam logic [1:0] SRC_OPER = 2'h1;
  // Sizes, reset values and bus answers.
  localparam logic [9:0]       BUF_MAX     = 10'h200;
  localparam logic [9:0]       LOC_FIRST   = 10'h001;
  localparam logic [9:0]       BUFSIZE_RST = 10'h200;
  localparam logic [DLY_W-1:0] DELAY_RST   = 24'h000000;
  localparam logic [DLY_W-1:0] INTVL_RST   = 24'h000000;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic       stored_src;
    logic       talk_only;
    logic [1:0] src;
    logic       single_shot;
  } cfg_s;
  localparam cfg_s CFG_RST = 5'h01;
  typedef enum logic [1:0] {VIEW_LOC, VIEW_MAX, VIEW_MIN} view_e;
  typedef struct packed {
    logic [9:0] count;
    logic [1:0] view;
    logic       tx_busy;
    logic       dump;
    logic       no_data;
    logic       recall;
    logic       overrun;
    logic       run;
    logic       armed;
  } status_s;
endpackage

// ===== hdl/trigger_delay.sv
// Trigger delay counter with overrun detection.
`timescale 1ns/10ps
module trigger_delay
  import rstore_pkg::*;
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Stimulus and delay in cycles
  input  wire logic             stim,
  input  wire logic [DLY_W-1:0] delay,
  // Results
  output logic                  fire,
  output logic                  overrun,
  output logic                  busy
);
  logic [DLY_W-1:0] cnt_q;
  logic             busy_q;
  logic             fire_q;

  // A stimulus during the count neither restarts it nor fires.
  assign overrun = stim && busy_q;
  assign busy    = busy_q;
  assign fire    = fire_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      fire_q <= 1'b0;
    end else if (busy_q) begin
      fire_q <= cnt_q == '0;
      busy_q <= cnt_q != '0;
      cnt_q  <= cnt_q - 24'h000001;
    end else begin
      fire_q <= stim && delay == '0;
      busy_q <= stim && delay != '0;
      cnt_q  <= delay - 24'h000001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_delay_three_cycles: assert property (
    stim && !busy_q && delay == 24'h000003 |=> !fire [*3] ##1 fire)
    else $error("Fire did not follow a three-cycle delay.");
  a_overrun_no_reload: assert property (
    stim && busy_q && cnt_q != '0 |=> busy_q && cnt_q == $past(cnt_q) - 1)
    else $error("Stimulus during delay disturbed the count.");
endmodule // trigger_delay

// ===== verification/listener_model.sv
// Listen-only stream device model.
`timescale 1ns/10ps
module listener_model
  import rstore_pkg::*;
(
  // Clock and pacing
  input  wire logic          aclk,
  input  wire logic          slow,
  // Stream
  input  wire logic [DW-1:0] tx_data,
  input  wire logic          tx_valid,
  output logic               tx_ready,
  output logic [DW-1:0]      last_word,
  output int                 n_words
);
  logic [1:0] cnt_q;
  initial {tx_ready, cnt_q, last_word, n_words} = '0;
  // A slow device takes one word in four cycles; it never acts as bus controller.
  always @(posedge aclk) begin
    cnt_q <= cnt_q + 2'h1;
    tx_ready <= !slow || cnt_q == 2'h3;
    if (tx_valid && tx_ready) begin
      n_words <= n_words + 1;
      last_word <= tx_data;
    end
  end
endmodule // listener_model

// ===== verification/reading_store_tb_top.sv
// Self-checking bench for the reading store controller.
`timescale 1ns/10ps
module reading_store_tb_top
  import rstore_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ext_trig_n = 1, source_operate = 0, conv_valid = 0, slow = 1;
  logic awready, wready, bvalid, arready, rvalid, meas_trigger, store_armed, ovr;
  logic            tx_valid, tx_ready;
  logic [RA_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]     wdata = '0, rdata, v;
  logic [1:0]      bresp, rresp, r;
  logic [DW-1:0]   reading_in = '0, tx_data, lw;
  int              fails = 0, n_tests = 0, nw, i, n_fire = 0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (meas_trigger) n_fire <= n_fire + 1;
  reading_store dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ext_trig_n, .source_operate, .reading_in, .conv_valid, .meas_trigger,
    .store_armed, .trigger_overrun_error(ovr), .tx_data, .tx_valid, .tx_ready);
  listener_model lsn (.aclk, .slow, .tx_data, .tx_valid, .tx_ready, .last_word(lw),
    .n_words(nw));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic at, wt, bt;
    bt = 0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    for (int k = 0; k < 40 && !bt; k++) begin
      @(negedge aclk);
      {at, wt, bt, r} = {awvalid && awready, wvalid && wready, bvalid, bresp};
      @(posedge aclk);
      if (at) awvalid <= 0;
      if (wt) wvalid <= 0;
    end
    bready <= 0;
    if (!bt) begin fails++; final_report(); end
  endtask
  task automatic rd(input logic [7:0] a);
    logic at, dt;
    dt = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (int k = 0; k < 40 && !dt; k++) begin
      @(negedge aclk);
      {at, dt, v, r} = {arvalid && arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (at) arvalid <= 0;
    end
    rready <= 0;
    if (!dt) begin fails++; final_report(); end
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(OFS_CTRL); chk("ctrl", v, 32'h1);
    rd(OFS_BUFSIZE); chk("bufsize", v, 32'h200);
    rd(8'h40); chk("unmapped", r, RESP_SLVERR);
    wr(OFS_INTVL, 32'h5); chk("intvl_resp", r, RESP_SLVERR);
    rd(OFS_INTVL); chk("intvl", v, 32'h0);
    wr(OFS_CMD, 32'h2);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_DELAY, 32'h3);
    wr(OFS_CMD, 32'h1);
    reading_in <= 32'h11;
    wr(OFS_CMD, 32'h2);
    i = 0;
    do begin @(negedge aclk); i++; end while (!meas_trigger && i < 9);
    chk("delay", i, 3);
    @(posedge aclk);
    reading_in <= 32'h5;
    source_operate <= 1;
    repeat (6) @(posedge aclk);
    rd(OFS_STATUS); chk("count2", v[18:9], 2);
    wr(OFS_CMD, 32'h4); rd(OFS_RDATA); chk("first", v, 32'h11);
    wr(OFS_CMD, 32'h20); rd(OFS_RDATA); chk("max", v, 32'h11);
    wr(OFS_CMD, 32'h20); rd(OFS_RDATA); chk("min", v, 32'h5);
    repeat (4) wr(OFS_CMD, 32'h10);
    rd(OFS_RLOC); chk("fwd_stop", v, 32'h2);
    wr(OFS_DIGIT, 32'h1); rd(OFS_RLOC); chk("digit", v, 32'h1);
    wr(OFS_CMD, 32'h8);
    wr(OFS_DELAY, 32'h14); chk("disarm", store_armed, 0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_BUFSIZE, 32'h2);
    wr(OFS_CMD, 32'h1); rd(OFS_STATUS); chk("cleared", v[18:9], 0);
    ext_trig_n <= 0;
    @(posedge aclk) ext_trig_n <= 1;
    repeat (25) @(posedge aclk);
    rd(OFS_STATUS); chk("ext", v[18:9], 1);
    reading_in <= 32'h7;
    wr(OFS_CMD, 32'h2);
    wr(OFS_CMD, 32'h2); chk("ovr", ovr, 1);
    repeat (25) @(posedge aclk);
    rd(OFS_STATUS); chk("one_kept", v[18:9], 2); chk("one_fire", n_fire, 5);
    chk("armed_off", store_armed, 0);
    chk("ovr_held", v[2], 1);
    wr(OFS_CMD, 32'h40); chk("ovr_ack", ovr, 0);
    wr(OFS_CTRL, 32'h19);
    for (i = 0; i < 200 && nw < 2; i++) @(posedge aclk);
    chk("dump_n", nw, 2); chk("dump_last", lw, 32'h7);
    wr(OFS_CTRL, 32'h9);
    conv_valid <= 1;
    reading_in <= 32'h9;
    @(posedge aclk) conv_valid <= 0;
    repeat (12) @(posedge aclk);
    chk("live_n", nw, 3); chk("live", lw, 32'h9);
    wr(OFS_CMD, 32'h1); wr(OFS_CMD, 32'h4);
    rd(OFS_STATUS); chk("no_data", v[4], 1);
    wr(OFS_CTRL, 32'h18); wr(OFS_CMD, 32'h1); wr(OFS_CMD, 32'h2);
    repeat (25) @(posedge aclk);
    conv_valid <= 1;
    reading_in <= 32'hA;
    @(posedge aclk) conv_valid <= 0;
    repeat (12) @(posedge aclk);
    chk("stored_n", nw, 4); chk("stored", lw, 32'hA);
    rd(OFS_STATUS); chk("recall_run", v[18:9], 1);
    final_report();
  end
endmodule // reading_store_tb_top
